// >>> rtl/ccs_chg_bit.sv
// Purpose: One sticky change bit of the pin replacement register.
// Assumes: The status input is synchronous to the clock.
// Notes:   A status change in the cycle of a host write wins over it.
`timescale 1ns/100ps
module ccs_chg_bit (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic soft_reset_i,
  // Watched status and host write.
  input wire logic status_i,
  input wire logic wr_i,
  input wire logic wr_val_i,
  input wire logic wr_mask_i,
  // Sticky change flag.
  output logic chg_o
);

  logic prev_reg; // Status seen one cycle ago.
  logic primed_reg; // High once prev_reg holds a real sample.

  // Track the previous status; the first sample after reset only primes.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || soft_reset_i) begin
      prev_reg <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      prev_reg <= status_i;
      primed_reg <= 1'b1;
    end
  end

  // Set on any change, else take the masked host value.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || soft_reset_i) begin
      chg_o <= 1'b0;
    end else if (primed_reg && (status_i != prev_reg)) begin
      chg_o <= 1'b1;
    end else if (wr_i && wr_mask_i) begin
      chg_o <= wr_val_i;
    end
  end

endmodule : ccs_chg_bit

// >>> rtl/ccs_defines.svh
// Purpose: Offsets, field positions, reset values of the card registers.
// Assumes: Attribute memory addresses are 11 bits, A10 down to A0.
// Notes:   Definitions only; included by the main module only.
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// ------------------------------------------------------------------
// Attribute memory map
// ------------------------------------------------------------------
`define CCS_ADDR_W 11
`define CCS_CFG_BASE 11'h200
`define CCS_OFS_STATUS 11'h202
`define CCS_OFS_PINREP 11'h204
`define CCS_OFS_SOCKET 11'h206

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define CCS_RST_STATUS 8'h00
`define CCS_RST_PINREP 8'h0C
`define CCS_RST_SOCKET 8'h00

// ------------------------------------------------------------------
// Field positions, status-and-configuration register
// ------------------------------------------------------------------
`define CCS_ST_CHANGED 7
`define CCS_ST_STATUS_CHANGE_ENABLE 6
`define CCS_ST_IO8 5
`define CCS_ST_PWRDN 2
`define CCS_ST_INT 1

// ------------------------------------------------------------------
// Field positions, pin replacement and socket/copy registers
// ------------------------------------------------------------------
`define CCS_PR_RDYCHG 5
`define CCS_PR_WPCHG 4
`define CCS_PR_RDY 1
`define CCS_PR_WP 0
`define CCS_PR_FIXED1 8'h0C
`define CCS_SC_DRIVE 4

`endif

// >>> rtl/ccs_pkg.sv
// Purpose: Types shared by the card register bank.
// Assumes: Constants live in ccs_defines.svh.
// Notes:   Holds the decoded access kinds only.
package ccs_pkg;

  // Kind of PC Card cycle currently decoded from the pins.
  typedef enum {
    CCS_ACC_NONE,
    CCS_ACC_ATTR,
    CCS_ACC_IO
  } ccs_acc_t;

endpackage : ccs_pkg

// >>> rtl/ccs_regs.sv
// Purpose: Card configuration register bank and PC Card access decoding.
// Assumes: All pins are synchronous to core_clk_i; active-low pins as _n.
// Notes:   Read data appears one clock after the read is decoded.
//
// Overview of operation
// - Changed bit set if any change bit set
// - Status change output low when enabled
// - Status change output high when disabled
// - Power-down bit selects power saving mode
// - Ready busy until power state reached
// - Int bit mirrors internal interrupt request
// - Int reads zero when interrupts disabled
// - Status register resets 00h, fixed zeros
// - Ready change set on ready transition
// - Write-protect change set on its transition
// - Pin replacement D1 reads internal ready
// - Write-protect status always reads zero
// - Low write bits mask the change bits
// - Pin replacement resets 0Ch, fixed bits
// - Socket register keeps only drive bit
// - Attribute access byte wide, even lane
// - Information structure writes are ignored
// - No attribute access in True IDE
// - Sixteen-bit indication for every port
// - I/O byte lanes steered by enables
// - Registers at 202h, 204h, 206h
`timescale 1ns/100ps
`include "ccs_defines.svh"
module ccs_regs (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic soft_reset_i,
  // PC Card bus from the host.
  input wire logic ce1_n_i,
  input wire logic ce2_n_i,
  input wire logic reg_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic iord_n_i,
  input wire logic iowr_n_i,
  input wire logic [10:0] addr_i,
  input wire logic [15:0] data_i,
  // PC Card bus to the host.
  output logic [15:0] data_o,
  output logic [1:0] data_oe_o,
  output logic stschg_n_o,
  output logic iois16_n_o,
  // Card core status.
  input wire logic io_mode_i,
  input wire logic true_ide_i,
  input wire logic ready_i,
  input wire logic irq_i,
  input wire logic interrupt_enable_n_i,
  input wire logic pwr_saving_i,
  // Card core controls.
  output logic power_down_request_o,
  output logic eight_bit_io_request_o,
  output logic drive_select_o,
  // I/O transfers handed to the core.
  input wire logic [15:0] io_rdata_i,
  output logic io_rd_o,
  output logic io_wr_o,
  output logic [1:0] io_be_o,
  output logic [15:0] io_wdata_o
);
  import ccs_pkg::*;

  // ----------------------------------------------------------------
  // Access decoding
  // ----------------------------------------------------------------
  logic rst_any; // Hardware or soft reset.
  logic we_prev_reg; // Write strobe one cycle ago.
  logic iowr_prev_reg; // I/O write strobe one cycle ago.
  logic iord_prev_reg; // I/O read strobe one cycle ago.
  logic status_change_enable_reg; // Status change output enable.
  logic pwr_busy_reg; // Power state transition in progress.
  logic drive_reg; // Stored drive select.
  logic ready_change; // Sticky ready change.
  logic write_protect_change; // Sticky write-protect change.
  logic write_protect_raw; // Card has no switch, tied low.
  logic ready_int; // Internal ready status.
  logic chg_any; // Change summary.
  logic int_pending; // Interrupt bit as read.
  ccs_acc_t acc; // Decoded access kind.
  logic attr_wr; // Write edge into attribute space.
  logic cfg_wr; // Write edge into configuration region.
  logic [7:0] attr_rdata; // Attribute read value.
  logic [7:0] status_rd; // Status register as read.
  logic [7:0] pinrep_rd; // Pin replacement register as read.

  assign rst_any = !resetn_i || soft_reset_i;
  assign write_protect_raw = 1'b0;
  assign ready_int = ready_i && !pwr_busy_reg;
  assign chg_any = ready_change || write_protect_change;
  assign int_pending = irq_i && !interrupt_enable_n_i;

  // Classify the pin state; odd attribute cycles decode to nothing.
  always_comb begin
    acc = CCS_ACC_NONE;
    if (!reg_n_i && !true_ide_i) begin
      if (!ce1_n_i && !addr_i[0] && (!oe_n_i || !we_n_i)) begin
        acc = CCS_ACC_ATTR;
      end else if (io_mode_i && (!ce1_n_i || !ce2_n_i)
                   && (!iord_n_i || !iowr_n_i)) begin
        acc = CCS_ACC_IO;
      end
    end
  end

  // A write is taken once per strobe, on its falling edge.
  assign attr_wr = (acc == CCS_ACC_ATTR) && !we_n_i && we_prev_reg;
  // Only the configuration region accepts writes.
  assign cfg_wr = attr_wr && addr_i[9] && !addr_i[10];

  // Remember the strobes to find their falling edges.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      we_prev_reg <= 1'b1;
      iowr_prev_reg <= 1'b1;
      iord_prev_reg <= 1'b1;
    end else begin
      we_prev_reg <= we_n_i;
      iowr_prev_reg <= iowr_n_i;
      iord_prev_reg <= iord_n_i;
    end
  end

  // ----------------------------------------------------------------
  // Status-and-configuration register
  // ----------------------------------------------------------------
  // Writable fields; read-only and fixed bits are never stored.
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      status_change_enable_reg <= 1'b0;
      eight_bit_io_request_o <= 1'b0;
      power_down_request_o <= 1'b0;
    end else if (cfg_wr && addr_i == `CCS_OFS_STATUS) begin
      status_change_enable_reg <= data_i[`CCS_ST_STATUS_CHANGE_ENABLE];
      // Stored only; the card always handles 8 and 16 bit I/O.
      eight_bit_io_request_o <= data_i[`CCS_ST_IO8];
      power_down_request_o <= data_i[`CCS_ST_PWRDN];
    end
  end

  // Busy from a power-down bit change until the core reports the state.
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      pwr_busy_reg <= 1'b0;
    end else if (cfg_wr && addr_i == `CCS_OFS_STATUS
                 && data_i[`CCS_ST_PWRDN] != power_down_request_o) begin
      pwr_busy_reg <= 1'b1;
    end else if (pwr_saving_i == power_down_request_o) begin
      pwr_busy_reg <= 1'b0;
    end
  end

  // Assemble the read value; D4, D3 and D0 read zero.
  always_comb begin
    status_rd = `CCS_RST_STATUS;
    status_rd[`CCS_ST_CHANGED] = chg_any;
    status_rd[`CCS_ST_STATUS_CHANGE_ENABLE] = status_change_enable_reg;
    status_rd[`CCS_ST_IO8] = eight_bit_io_request_o;
    status_rd[`CCS_ST_PWRDN] = power_down_request_o;
    status_rd[`CCS_ST_INT] = int_pending;
  end

  // Drive the status change pin; high whenever not signalling.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      stschg_n_o <= 1'b1;
    end else begin
      stschg_n_o <= !(chg_any && io_mode_i
                      && status_change_enable_reg);
    end
  end

  // ----------------------------------------------------------------
  // Pin replacement register
  // ----------------------------------------------------------------
  logic pr_wr; // Write to pin replacement register.
  assign pr_wr = cfg_wr && addr_i == `CCS_OFS_PINREP;

  // Ready change bit, masked by the written D1.
  ccs_chg_bit u_rdy_chg (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .soft_reset_i(soft_reset_i),
    .status_i(ready_int),
    .wr_i(pr_wr),
    .wr_val_i(data_i[`CCS_PR_RDYCHG]),
    .wr_mask_i(data_i[`CCS_PR_RDY]),
    .chg_o(ready_change)
  );

  // Write-protect change bit, masked by the written D0.
  ccs_chg_bit u_wp_chg (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .soft_reset_i(soft_reset_i),
    .status_i(write_protect_raw),
    .wr_i(pr_wr),
    .wr_val_i(data_i[`CCS_PR_WPCHG]),
    .wr_mask_i(data_i[`CCS_PR_WP]),
    .chg_o(write_protect_change)
  );

  // D3 and D2 read one, D7 and D6 read zero.
  always_comb begin
    pinrep_rd = `CCS_PR_FIXED1;
    pinrep_rd[`CCS_PR_RDYCHG] = ready_change;
    pinrep_rd[`CCS_PR_WPCHG] = write_protect_change;
    pinrep_rd[`CCS_PR_RDY] = ready_int;
    pinrep_rd[`CCS_PR_WP] = write_protect_raw;
  end

  // ----------------------------------------------------------------
  // Socket/copy register
  // ----------------------------------------------------------------
  // Keep the drive select; the socket number is dropped.
  always_ff @(posedge core_clk_i) begin
    if (rst_any) begin
      drive_reg <= 1'b0;
    end else if (cfg_wr && addr_i == `CCS_OFS_SOCKET) begin
      drive_reg <= data_i[`CCS_SC_DRIVE];
    end
  end
  assign drive_select_o = drive_reg;

  // ----------------------------------------------------------------
  // Read path and I/O steering
  // ----------------------------------------------------------------
  // Pick the addressed register; anything else reads as zero.
  always_comb begin
    attr_rdata = 8'h00;
    if (addr_i == `CCS_OFS_STATUS) begin
      attr_rdata = status_rd;
    end else if (addr_i == `CCS_OFS_PINREP) begin
      attr_rdata = pinrep_rd;
    end else if (addr_i == `CCS_OFS_SOCKET) begin
      attr_rdata = {3'h0, drive_reg, 4'h0};
    end
  end

  // Register the data lanes and their enables every cycle.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      data_o <= 16'h0000;
      data_oe_o <= 2'h0;
    end else begin
      data_o <= 16'h0000;
      data_oe_o <= 2'h0;
      unique case (acc)
        CCS_ACC_ATTR: begin
          if (!oe_n_i && we_n_i) begin
            data_o <= {8'h00, attr_rdata};
            data_oe_o <= 2'h1;
          end
        end
        CCS_ACC_IO: begin
          if (!iord_n_i) begin
            if (!ce1_n_i && !ce2_n_i) begin
              data_o <= io_rdata_i;
              data_oe_o <= 2'h3;
            end else if (!ce1_n_i) begin
              data_o <= {8'h00, addr_i[0] ? io_rdata_i[15:8]
                                          : io_rdata_i[7:0]};
              data_oe_o <= 2'h1;
            end else begin
              data_o <= {io_rdata_i[15:8], 8'h00};
              data_oe_o <= 2'h2;
            end
          end
        end
        CCS_ACC_NONE: begin
          data_oe_o <= 2'h0;
        end
      endcase
    end
  end

  // Every addressed I/O port takes 16 bit transfers.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      iois16_n_o <= 1'b1;
    end else begin
      iois16_n_o <= !(acc == CCS_ACC_IO);
    end
  end

  // Hand one pulse per I/O strobe to the core with steered lanes.
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      io_rd_o <= 1'b0;
      io_wr_o <= 1'b0;
      io_be_o <= 2'h0;
      io_wdata_o <= 16'h0000;
    end else begin
      io_rd_o <= (acc == CCS_ACC_IO) && !iord_n_i && iord_prev_reg;
      io_wr_o <= (acc == CCS_ACC_IO) && !iowr_n_i && iowr_prev_reg;
      if (acc == CCS_ACC_IO) begin
        if (!ce1_n_i && !ce2_n_i) begin
          io_be_o <= 2'h3;
          io_wdata_o <= data_i;
        end else if (!ce1_n_i) begin
          io_be_o <= addr_i[0] ? 2'h2 : 2'h1;
          io_wdata_o <= addr_i[0] ? {data_i[7:0], 8'h00}
                                  : {8'h00, data_i[7:0]};
        end else begin
          io_be_o <= 2'h2;
          io_wdata_o <= {data_i[15:8], 8'h00};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_status_rd;
    acc == CCS_ACC_ATTR && !oe_n_i && we_n_i
      && addr_i == `CCS_OFS_STATUS;
  endsequence

  sequence s_pd_toggle;
    cfg_wr && addr_i == `CCS_OFS_STATUS && !soft_reset_i
      && data_i[`CCS_ST_PWRDN] != power_down_request_o;
  endsequence

  a_stschg_low: assert property (
    chg_any && io_mode_i && status_change_enable_reg |=> !stschg_n_o)
    else $error("status change pin not low while signalling");

  a_stschg_high: assert property (
    !status_change_enable_reg && io_mode_i |=> stschg_n_o)
    else $error("status change pin low while disabled");

  a_pd_follow: assert property (
    s_pd_toggle |=> power_down_request_o == $past(data_i[`CCS_ST_PWRDN]))
    else $error("power-down request did not follow write");

  a_pd_busy: assert property (
    s_pd_toggle |=> pwr_busy_reg ##0 !pinrep_rd[`CCS_PR_RDY])
    else $error("ready not busy after power-down change");

  a_int_masked: assert property (
    s_status_rd ##0 interrupt_enable_n_i |=> !data_o[`CCS_ST_INT])
    else $error("interrupt bit read while disabled");

  a_summary_bit: assert property (
    s_status_rd |=> data_o[`CCS_ST_CHANGED] == $past(chg_any))
    else $error("change summary bit wrong");

  a_pinrep_fixed: assert property (
    acc == CCS_ACC_ATTR && !oe_n_i && we_n_i
      && addr_i == `CCS_OFS_PINREP
      |=> (data_o[7:0] & 8'hCD) == 8'h0C)
    else $error("pin replacement fixed bits wrong");

  a_attr_lane: assert property (
    acc == CCS_ACC_ATTR |=> !data_oe_o[1])
    else $error("upper lane driven on attribute access");

  a_cis_nowrite: assert property (
    attr_wr && !addr_i[9] && !soft_reset_i
      |=> $stable(drive_reg) && $stable(power_down_request_o))
    else $error("information structure write changed a register");

  a_iois16: assert property (
    acc == CCS_ACC_IO |=> !iois16_n_o)
    else $error("16 bit indication missing on I/O access");

endmodule : ccs_regs

// >>> verification/ccs_host_model.sv
// Purpose: Host socket controller model driving the card bus.
// Assumes: Pins change only at the falling clock edge.
// Notes:   Released data lines show the inverse of their last value.
`timescale 1ns/100ps
module ccs_host_model (
  // Clock and card answers.
  input wire logic clk_i,
  input wire logic [15:0] rd_data_i,
  input wire logic [1:0] rd_oe_i,
  input wire logic pulse_i,
  input wire logic iois_n_i,
  // Card bus driven by the host.
  output logic ce1_n_o,
  output logic ce2_n_o,
  output logic reg_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic iord_n_o,
  output logic iowr_n_o,
  output logic [10:0] addr_o,
  output logic [15:0] wdata_o
);
  // Ends a cycle; strobes go high so the next cycle is a fresh one.
  task automatic idle();
    {ce1_n_o, ce2_n_o, reg_n_o, oe_n_o} = 4'hF;
    {we_n_o, iord_n_o, iowr_n_o} = 3'h7;
    wdata_o = ~wdata_o;
  endtask : idle

  // Bus starts idle at time zero.
  initial begin
    wdata_o = 16'h0000;
    addr_o = 11'h000;
    idle();
  end

  // Byte write to attribute memory; data on the low lane, strobe low for one clock.
  task automatic attr_wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {reg_n_o, ce1_n_o, addr_o, wdata_o} = {2'h0, a, 8'h00, d};
    we_n_o = 1'h0;
    @(negedge clk_i);
    idle();
  endtask : attr_wr

  // Attribute read; select and read strobe held for the whole cycle.
  task automatic attr_rd(input logic [10:0] a, input logic c2n,
                         output logic [15:0] d, output logic [1:0] oe);
    @(negedge clk_i);
    {reg_n_o, ce1_n_o, ce2_n_o, addr_o} = {2'h0, c2n, a};
    oe_n_o = 1'h0;
    repeat (3) @(negedge clk_i);
    d = rd_data_i;
    oe = rd_oe_i;
    idle();
  endtask : attr_rd

  // One I/O transfer; counts strobe pulses seen by the core.
  task automatic io_cyc(input logic c1n, c2n, a0, wr,
                        input logic [15:0] w, output logic [15:0] d,
                        output logic [1:0] oe, output logic [1:0] np,
                        output logic s16n);
    np = 2'h0;
    @(negedge clk_i);
    {reg_n_o, ce1_n_o, ce2_n_o} = {1'h0, c1n, c2n};
    {addr_o, wdata_o} = {10'h000, a0, w};
    {iowr_n_o, iord_n_o} = {!wr, wr};
    repeat (3) begin
      @(negedge clk_i);
      np = np + {1'h0, pulse_i};
    end
    {d, oe, s16n} = {rd_data_i, rd_oe_i, iois_n_i};
    idle();
  endtask : io_cyc
endmodule : ccs_host_model

// >>> verification/ccs_regs_tb.sv
// Purpose: Self-checking bench for the card register bank.
// Assumes: Host model drives the bus; bench drives the core status.
// Notes:   Expected values come from the register layouts.
`timescale 1ns/100ps
module ccs_regs_tb;
  import ccs_pkg::*;
  logic core_clk = 1'h0;
  logic resetn, soft_reset, io_mode, true_ide, ready, irq, ien_n;
  logic pwr_saving, ce1_n, ce2_n, reg_n, oe_n, we_n, iord_n, iowr_n;
  logic stschg_n, iois16_n, pd_req, io8_req, drive_sel, io_rd, io_wr;
  logic [10:0] addr;
  logic [15:0] wdata, rdata, io_rdata, io_wdata, d;
  logic [1:0] rd_oe, io_be, oe, np;
  logic s16n;
  int checks = 0;
  int fail_count = 0;
  // I/O lane table, entries {ce1_n, ce2_n, A0}.
  logic [2:0] sel_t [4] = '{3'h2, 3'h3, 3'h0, 3'h4};
  logic [1:0] be_t [4] = '{2'h1, 2'h2, 2'h3, 2'h2};
  logic [1:0] ro_t [4] = '{2'h1, 2'h1, 2'h3, 2'h2};
  logic [15:0] wd_t [4] = '{16'h0034, 16'h3400, 16'h1234, 16'h1200};
  logic [15:0] rd_t [4] = '{16'h005A, 16'h00A5, 16'hA55A, 16'hA500};

  // 100 MHz clock.
  always #5 core_clk = ~core_clk;

  ccs_regs dut_u (.core_clk_i(core_clk), .resetn_i(resetn),
    .soft_reset_i(soft_reset), .ce1_n_i(ce1_n), .ce2_n_i(ce2_n),
    .reg_n_i(reg_n), .oe_n_i(oe_n), .we_n_i(we_n), .iord_n_i(iord_n),
    .iowr_n_i(iowr_n), .addr_i(addr), .data_i(wdata), .data_o(rdata),
    .data_oe_o(rd_oe), .stschg_n_o(stschg_n), .iois16_n_o(iois16_n),
    .io_mode_i(io_mode), .true_ide_i(true_ide), .ready_i(ready),
    .irq_i(irq), .interrupt_enable_n_i(ien_n),
    .pwr_saving_i(pwr_saving), .power_down_request_o(pd_req),
    .eight_bit_io_request_o(io8_req), .drive_select_o(drive_sel),
    .io_rdata_i(io_rdata), .io_rd_o(io_rd), .io_wr_o(io_wr),
    .io_be_o(io_be), .io_wdata_o(io_wdata));

  ccs_host_model host_u (.clk_i(core_clk), .rd_data_i(rdata),
    .rd_oe_i(rd_oe), .pulse_i(io_rd | io_wr), .iois_n_i(iois16_n),
    .ce1_n_o(ce1_n), .ce2_n_o(ce2_n), .reg_n_o(reg_n), .oe_n_o(oe_n),
    .we_n_o(we_n), .iord_n_o(iord_n), .iowr_n_o(iowr_n),
    .addr_o(addr), .wdata_o(wdata));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Reads a register; only the even lane may be driven.
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    host_u.attr_rd(a, 1'h1, d, oe);
    chk("attr_data", {8'h00, e}, {8'h00, d[7:0]});
    chk("attr_lanes", 16'h0001, {14'h0000, oe});
  endtask : rd

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // Watchdog sized well past the expected run length.
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    close_out();
  end

  // --------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------
  initial begin
    {soft_reset, io_mode, true_ide, ready, irq} = 5'h00;
    {ien_n, pwr_saving, resetn} = 3'h0;
    io_rdata = 16'hA55A;
    repeat (20) @(negedge core_clk);
    resetn = 1'h1;
    rd(11'h202, 8'h00);
    rd(11'h204, 8'h0C);
    rd(11'h206, 8'h00);
    host_u.attr_wr(11'h202, 8'hFF);
    rd(11'h202, 8'h64);
    chk("ctrl", 16'h0003, {14'h0000, pd_req, io8_req});
    pwr_saving = 1'h1;
    host_u.attr_wr(11'h202, 8'h00);
    pwr_saving = 1'h0;
    chk("ctrl", 16'h0000, {14'h0000, pd_req, io8_req});
    rd(11'h204, 8'h0C);
    ready = 1'h1;
    rd(11'h204, 8'h2E);
    rd(11'h202, 8'h80);
    host_u.attr_wr(11'h204, 8'h02);
    rd(11'h204, 8'h0E);
    host_u.attr_wr(11'h204, 8'h20);
    rd(11'h204, 8'h0E);
    host_u.attr_wr(11'h202, 8'h04);
    rd(11'h204, 8'h2C);
    pwr_saving = 1'h1;
    rd(11'h204, 8'h2E);
    io_mode = 1'h1;
    host_u.attr_wr(11'h202, 8'h44);
    repeat (2) @(negedge core_clk);
    chk("stschg", 16'h0000, {15'h0000, stschg_n});
    host_u.attr_wr(11'h202, 8'h04);
    repeat (2) @(negedge core_clk);
    chk("stschg", 16'h0001, {15'h0000, stschg_n});
    host_u.attr_wr(11'h204, 8'h31);
    rd(11'h204, 8'h3E);
    host_u.attr_wr(11'h204, 8'h03);
    rd(11'h202, 8'h04);
    irq = 1'h1;
    rd(11'h202, 8'h06);
    ien_n = 1'h1;
    rd(11'h202, 8'h04);
    host_u.attr_wr(11'h206, 8'hFF);
    rd(11'h206, 8'h10);
    chk("drive", 16'h0001, {15'h0000, drive_sel});
    host_u.attr_wr(11'h006, 8'h00);
    host_u.attr_wr(11'h207, 8'h00);
    true_ide = 1'h1;
    host_u.attr_wr(11'h206, 8'h00);
    host_u.attr_rd(11'h206, 1'h1, d, oe);
    chk("ide_lanes", 16'h0000, {14'h0000, oe});
    true_ide = 1'h0;
    rd(11'h206, 8'h10);
    host_u.attr_rd(11'h206, 1'h0, d, oe);
    chk("word_lanes", 16'h0001, {14'h0000, oe});
    for (int i = 0; i < 4; i++) begin
      host_u.io_cyc(sel_t[i][2], sel_t[i][1], sel_t[i][0], 1'h1,
                    16'h1234, d, oe, np, s16n);
      chk("io_wr", 16'h0001, {14'h0000, np});
      chk("io_be", {14'h0000, be_t[i]}, {14'h0000, io_be});
      chk("io_wdata", wd_t[i], io_wdata & {{8{be_t[i][1]}},
          {8{be_t[i][0]}}});
      chk("iois16", 16'h0000, {15'h0000, s16n});
      host_u.io_cyc(sel_t[i][2], sel_t[i][1], sel_t[i][0], 1'h0,
                    16'h0000, d, oe, np, s16n);
      chk("io_lanes", {14'h0000, ro_t[i]}, {14'h0000, oe});
      chk("io_rd", 16'h0001, {14'h0000, np});
      chk("io_rdata", rd_t[i], d & {{8{ro_t[i][1]}},
          {8{ro_t[i][0]}}});
    end
    io_mode = 1'h0;
    host_u.io_cyc(1'h0, 1'h0, 1'h0, 1'h1, 16'h1234, d, oe, np, s16n);
    chk("io_off", 16'h0000, {14'h0000, np});
    @(negedge core_clk);
    soft_reset = 1'h1;
    @(negedge core_clk);
    soft_reset = 1'h0;
    rd(11'h206, 8'h00);
    rd(11'h202, 8'h00);
    close_out();
  end
endmodule : ccs_regs_tb
